/* src/ctse_scrub.sv */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module ctse_scrub import ctse_pkg::*; #(
  parameter int N_SETS = SETS,
  parameter int N_WAYS = WAYS
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic C1_VALID,
  input wire logic [3:0] C1_KIND,
  input wire logic C1_FROM_QUEUE,
  input wire logic C1_FB_HIT,
  input wire logic [IDX_W-1:0] C1_INDEX,
  input wire logic [PA_W-1:0] C1_PA,
  input wire logic C1_FWD_SEL,
  input wire logic [DATA_W-1:0] C1_FWD_VD,
  input wire logic [DATA_W-1:0] C1_FWD_UA,
  input wire logic C2_TAG_PERR,
  input wire logic FILL_DONE,
  input wire logic STATE_WR,
  input wire logic STATE_WR_UA,
  input wire logic STATE_WR_RAW,
  input wire logic [IDX_W-1:0] STATE_WR_INDEX,
  input wire logic [DATA_W-1:0] STATE_WR_DATA,
  input wire logic [SYN_W-1:0] STATE_WR_CHECK,
  input wire logic TAG_WR,
  input wire logic TAG_WR_RAW,
  input wire logic [IDX_W-1:0] TAG_WR_INDEX,
  input wire logic [WAY_W-1:0] TAG_WR_WAY,
  input wire logic [TAG_W-1:0] TAG_WR_DATA,
  input wire logic [CHK_W-1:0] TAG_WR_CHECK,
  output logic STALL_PIPE,
  output logic QUEUE_INSERT,
  output logic QUEUE_TAG_SCRUB,
  output logic QUEUE_DEP,
  output logic QUEUE_WRI_HOLD,
  output logic DIR_GATE,
  output logic CORE_RESP_GATE,
  output logic SIU_RESP_GATE,
  output logic WBB_COPY_GATE,
  output logic QUEUE_READY,
  output logic QUEUE_MEM_HOLD,
  output logic QUEUE_CE_REPLAY,
  output logic QUEUE_EVICT_KEEP,
  output logic FATAL_RESET_REQ,
  output logic ERR_PKT_VALID,
  output logic [1:0] ERR_PKT_BITS,
  output logic [TGT_W-1:0] ERR_PKT_TARGET
);
  // ------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------
  if (N_WAYS < 2 || N_WAYS > 2 ** WAY_W || N_SETS < 1 || N_SETS > 2 ** IDX_W) begin : g_chk
    $error("ctse_scrub: unsupported geometry");
  end
  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  logic [CODE_W-1:0] vd_mem [0:N_SETS-1];
  logic [CODE_W-1:0] ua_mem [0:N_SETS-1];
  logic [TAG_CODE_W-1:0] tag_mem [0:N_SETS*N_WAYS-1];
  // ------------------------------------------------------------
  // C2 stage
  // ------------------------------------------------------------
  logic c2_valid;
  logic c2_from_array;
  logic c2_from_queue;
  logic c2_fb_hit;
  ctse_kind_type c2_kind;
  logic [IDX_W-1:0] c2_index;
  logic [PA_W-1:0] c2_pa;
  logic [CODE_W-1:0] c2_vd;
  logic [CODE_W-1:0] c2_ua;
  logic stall;
  logic accept;
  assign accept = C1_VALID && !stall;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      c2_valid <= 1'b0;
    end else if (CE && !stall) begin
      c2_valid <= C1_VALID;
    end
  end
  always_ff @(posedge CLK) begin
    if (CE && accept) begin
      c2_kind <= ctse_kind_type'(C1_KIND);
      c2_from_queue <= C1_FROM_QUEUE;
      c2_fb_hit <= C1_FB_HIT;
      c2_index <= C1_INDEX;
      c2_pa <= C1_PA;
      c2_from_array <= !C1_FWD_SEL;
      if (C1_FWD_SEL) begin
        c2_vd <= ctse_encode(C1_FWD_VD);
        c2_ua <= ctse_encode(C1_FWD_UA);
      end else begin
        c2_vd <= vd_mem[C1_INDEX];
        c2_ua <= ua_mem[C1_INDEX];
      end
    end
  end
  // ------------------------------------------------------------
  // C2 state check and correction
  // ------------------------------------------------------------
  logic [DATA_W-1:0] vd_fix;
  logic [DATA_W-1:0] ua_fix;
  logic [SYN_W-1:0] vd_syn;
  logic [SYN_W-1:0] ua_syn;
  logic vd_ce;
  logic vd_ue;
  logic ua_ce;
  logic ua_ue;
  ctse_secded #(.DED(1'b1)) u_vd (
    .data_in(c2_vd[DATA_W-1:0]),
    .check_in(c2_vd[CODE_W-1:DATA_W]),
    .data_out(vd_fix),
    .syndrome(vd_syn),
    .single_err(vd_ce),
    .double_err(vd_ue)
  );
  ctse_secded #(.DED(1'b1)) u_ua (
    .data_in(c2_ua[DATA_W-1:0]),
    .check_in(c2_ua[CODE_W-1:DATA_W]),
    .data_out(ua_fix),
    .syndrome(ua_syn),
    .single_err(ua_ce),
    .double_err(ua_ue)
  );
  logic detect_ok;
  logic tag_ok;
  logic any_ce;
  logic any_ue;
  logic pass_ce;
  logic pass_ue;
  logic pass_fix;
  logic tag_perr;
  always_comb begin
    case (c2_kind)
      K_LOAD, K_STORE, K_ATOMIC, K_IFETCH, K_BLK_READ, K_PART_WRITE, K_WRITE_INV,
      K_EVICT: detect_ok = !(c2_from_queue && c2_fb_hit);
      default: detect_ok = 1'b0;
    endcase
    case (c2_kind)
      K_DIAG, K_INVAL, K_PF_FLUSH, K_TECC, K_FILL: tag_ok = 1'b0;
      default: tag_ok = 1'b1;
    endcase
  end
  assign any_ce = c2_from_array && (vd_ce || ua_ce);
  assign any_ue = c2_from_array && (vd_ue || ua_ue);
  assign pass_ce = c2_valid && detect_ok && any_ce && !any_ue;
  assign pass_ue = c2_valid && (c2_kind != K_DIAG) && any_ue;
  assign pass_fix = c2_valid && (c2_kind != K_DIAG) && any_ce && !any_ue;
  assign tag_perr = c2_valid && tag_ok && C2_TAG_PERR;
  // ------------------------------------------------------------
  // C3..C8 stage registers
  // ------------------------------------------------------------
  logic [8:3] st_valid;
  logic [8:3] st_ce;
  logic [8:3] st_fix;
  logic [8:3] st_queue;
  logic [8:3] st_tperr;
  ctse_kind_type st_kind [3:8];
  logic [IDX_W-1:0] st_index [3:8];
  logic [PA_W-1:0] st_pa [3:8];
  logic [SYN_W-1:0] st_syn [3:8];
  logic [CODE_W-1:0] st_vd [3:5];
  logic [CODE_W-1:0] st_ua [3:5];
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_valid <= '0;
      st_ce <= '0;
      st_fix <= '0;
    end else if (CE && !stall) begin
      st_valid <= {st_valid[7:3], c2_valid};
      st_ce <= {st_ce[7:3], pass_ce};
      st_fix <= {st_fix[7:3], pass_fix};
    end
  end
  always_ff @(posedge CLK) begin
    if (CE && !stall) begin
      st_queue <= {st_queue[7:3], c2_from_queue};
      st_tperr <= {st_tperr[7:3], tag_perr};
      st_kind[3] <= c2_kind;
      st_index[3] <= c2_index;
      st_pa[3] <= c2_pa;
      st_syn[3] <= (c2_from_array && (vd_ce || vd_ue)) ? vd_syn : ua_syn;
      st_vd[3] <= ctse_encode(vd_fix);
      st_ua[3] <= ctse_encode(ua_fix);
      for (int s = 4; s <= 8; s++) begin
        st_kind[s] <= st_kind[s-1];
        st_index[s] <= st_index[s-1];
        st_pa[s] <= st_pa[s-1];
        st_syn[s] <= st_syn[s-1];
      end
      for (int s = 4; s <= 5; s++) begin
        st_vd[s] <= st_vd[s-1];
        st_ua[s] <= st_ua[s-1];
      end
    end
  end
  // ------------------------------------------------------------
  // State array writes: C5 correction, then external port
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (CE) begin
      if (!stall && st_valid[5] && st_fix[5]) begin
        vd_mem[st_index[5]] <= st_vd[5];
        ua_mem[st_index[5]] <= st_ua[5];
      end else if (STATE_WR) begin
        if (STATE_WR_UA) begin
          ua_mem[STATE_WR_INDEX] <= STATE_WR_RAW ? {STATE_WR_CHECK, STATE_WR_DATA}
                                                 : ctse_encode(STATE_WR_DATA);
        end else begin
          vd_mem[STATE_WR_INDEX] <= STATE_WR_RAW ? {STATE_WR_CHECK, STATE_WR_DATA}
                                                 : ctse_encode(STATE_WR_DATA);
        end
      end
    end
  end
  // ------------------------------------------------------------
  // Pass outputs: C3, C4, C7, C9 pulses
  // ------------------------------------------------------------
  logic siu6;
  assign siu6 = st_kind[6] inside {K_BLK_READ, K_PART_WRITE, K_WRITE_INV};
  always_ff @(posedge CLK) begin
    if (SRST) begin
      QUEUE_INSERT <= 1'b0;
      QUEUE_TAG_SCRUB <= 1'b0;
      QUEUE_DEP <= 1'b0;
      QUEUE_WRI_HOLD <= 1'b0;
      DIR_GATE <= 1'b0;
      CORE_RESP_GATE <= 1'b0;
      SIU_RESP_GATE <= 1'b0;
      WBB_COPY_GATE <= 1'b0;
      QUEUE_READY <= 1'b0;
      QUEUE_MEM_HOLD <= 1'b0;
      QUEUE_CE_REPLAY <= 1'b0;
      QUEUE_EVICT_KEEP <= 1'b0;
    end else if (CE) begin
      QUEUE_INSERT <= !stall && ((pass_ce && !c2_from_queue) || tag_perr);
      QUEUE_TAG_SCRUB <= !stall && tag_perr;
      QUEUE_DEP <= !stall && pass_ce && !c2_from_queue;
      QUEUE_WRI_HOLD <= !stall && pass_ce && (c2_kind == K_WRITE_INV);
      DIR_GATE <= !stall && st_valid[3] && st_ce[3];
      CORE_RESP_GATE <= !stall && st_valid[6] && st_ce[6] && !siu6;
      SIU_RESP_GATE <= !stall && st_valid[6] && st_ce[6] && siu6;
      WBB_COPY_GATE <= !stall && st_valid[6] && st_ce[6] && (st_kind[6] == K_EVICT);
      QUEUE_READY <= !stall && st_valid[8] && st_ce[8] && !st_queue[8] && !st_tperr[8];
      QUEUE_MEM_HOLD <= !stall && st_valid[8] && st_ce[8];
      QUEUE_CE_REPLAY <= !stall && st_valid[8] && st_ce[8] && st_queue[8]
                         && (st_kind[8] != K_EVICT);
      QUEUE_EVICT_KEEP <= !stall && st_valid[8] && st_ce[8] && (st_kind[8] == K_EVICT);
    end
  end
  // ------------------------------------------------------------
  // Tag scrub walk
  // ------------------------------------------------------------
  ctse_scrub_type scrub_state;
  logic [WAY_W-1:0] scrub_way;
  logic [2:0] scrub_step;
  logic [IDX_W-1:0] scrub_index;
  logic [TAG_CODE_W-1:0] scrub_raw;
  logic [TAG_CODE_W-1:0] scrub_mux;
  logic [TAG_CODE_W-1:0] scrub_fix;
  logic [7:0] scrub_fixed;
  logic [DATA_W-1:0] tag_out;
  logic tag_ce;
  logic [CHK_W-1:0] tag_enc;
  assign stall = STALL_PIPE;
  assign tag_enc = ctse_check({{(DATA_W-TAG_W){1'b0}}, tag_out[TAG_W-1:0]});
  ctse_secded #(.DED(1'b0)) u_tag (
    .data_in({{(DATA_W-TAG_W){1'b0}}, scrub_mux[TAG_W-1:0]}),
    .check_in({1'b0, scrub_mux[TAG_CODE_W-1:TAG_W]}),
    .data_out(tag_out),
    .syndrome(),
    .single_err(tag_ce),
    .double_err()
  );
  always_ff @(posedge CLK) begin
    if (SRST) begin
      scrub_state <= S_IDLE;
      STALL_PIPE <= 1'b0;
      scrub_way <= '0;
      scrub_step <= '0;
      scrub_fixed <= '0;
    end else if (CE) begin
      case (scrub_state)
        S_IDLE: begin
          if (accept && (ctse_kind_type'(C1_KIND) == K_TECC)) begin
            scrub_state <= S_WALK;
            STALL_PIPE <= 1'b1;
            scrub_way <= '0;
            scrub_step <= '0;
          end
        end
        S_WALK: begin
          scrub_step <= scrub_step + 3'h1;
          if (scrub_step == STEP_CORRECT && tag_ce) begin
            scrub_fixed <= scrub_fixed + 8'h01;
          end
          if (scrub_step == STEP_WRITE) begin
            scrub_way <= scrub_way + 4'h1;
            if (scrub_way == WAY_W'(N_WAYS - 1)) begin
              scrub_state <= S_IDLE;
              STALL_PIPE <= 1'b0;
            end
          end
        end
        default: begin
          scrub_state <= S_IDLE;
          STALL_PIPE <= 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge CLK) begin
    if (CE) begin
      if (scrub_state == S_IDLE && accept) scrub_index <= C1_INDEX;
      if (scrub_state == S_WALK && scrub_step == STEP_TAG_READ) begin
        scrub_raw <= tag_mem[{scrub_index, scrub_way}];
      end
      if (scrub_state == S_WALK && scrub_step == STEP_MUX) scrub_mux <= scrub_raw;
      if (scrub_state == S_WALK && scrub_step == STEP_CORRECT) begin
        scrub_fix <= {tag_enc, tag_out[TAG_W-1:0]};
      end
      if (scrub_state == S_WALK && scrub_step == STEP_WRITE) begin
        tag_mem[{scrub_index, scrub_way}] <= scrub_fix;
      end else if (TAG_WR && scrub_state == S_IDLE) begin
        tag_mem[{TAG_WR_INDEX, TAG_WR_WAY}] <= TAG_WR_RAW ? {TAG_WR_CHECK, TAG_WR_DATA}
          : {ctse_check({{(DATA_W-TAG_W){1'b0}}, TAG_WR_DATA}), TAG_WR_DATA};
      end
    end
  end
  // ------------------------------------------------------------
  // Error status, logging and reporting
  // ------------------------------------------------------------
  logic [31:0] control;
  logic ue_flag;
  logic ce_flag;
  logic [SYN_W-1:0] err_syn;
  logic [PA_W-1:0] err_pa;
  logic report_pending;
  logic log_ce;
  logic wr_en;
  logic clr_ue;
  logic clr_ce;
  logic fire;
  assign log_ce = !stall && st_valid[8] && st_ce[8]
                  && (st_kind[8] inside {K_LOAD, K_STORE, K_ATOMIC, K_IFETCH,
                                         K_BLK_READ, K_PART_WRITE, K_WRITE_INV});
  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;
  assign clr_ue = wr_en && PADDR == ADDR_STATUS && PWDATA[STS_UE_BIT];
  assign clr_ce = wr_en && PADDR == ADDR_STATUS && PWDATA[STS_CE_BIT];
  assign fire = FILL_DONE && report_pending && control[CTL_REPORT_EN_BIT];
  always_ff @(posedge CLK) begin
    if (SRST) begin
      control <= CTL_RESET;
      ue_flag <= 1'b0;
      ce_flag <= 1'b0;
      err_syn <= '0;
      err_pa <= '0;
      report_pending <= 1'b0;
      FATAL_RESET_REQ <= 1'b0;
      ERR_PKT_VALID <= 1'b0;
      ERR_PKT_BITS <= '0;
      ERR_PKT_TARGET <= '0;
    end else if (CE) begin
      if (wr_en && PADDR == ADDR_CONTROL) control <= PWDATA;
      if (!stall && pass_ue) ue_flag <= 1'b1;
      else if (clr_ue) ue_flag <= 1'b0;
      FATAL_RESET_REQ <= ue_flag;
      if (log_ce) begin
        ce_flag <= 1'b1;
        err_syn <= st_syn[8];
        err_pa <= st_pa[8];
      end else if (clr_ce) begin
        ce_flag <= 1'b0;
      end
      if (log_ce) report_pending <= 1'b1;
      else if (fire) report_pending <= 1'b0;
      ERR_PKT_VALID <= fire;
      ERR_PKT_BITS <= fire ? REPORT_CE_CODE : 2'h0;
      ERR_PKT_TARGET <= control[CTL_TARGET_LSB +: TGT_W];
    end
  end
  // ------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
      if (PSEL && PENABLE && !PREADY) begin
        case (PADDR)
          ADDR_CONTROL: PRDATA <= control;
          ADDR_STATUS: PRDATA <= {16'h0000, 1'b0, err_syn, 6'h00, ce_flag, ue_flag};
          ADDR_ERR_LO: PRDATA <= err_pa[31:0];
          ADDR_ERR_HI: PRDATA <= {24'h000000, err_pa[PA_W-1:32]};
          ADDR_SCRUB: PRDATA <= {scrub_fixed, 13'h0000, STALL_PIPE, scrub_way,
                                 3'h0, scrub_step};
          default: PSLVERR <= 1'b1;
        endcase
      end
    end
  end
endmodule : ctse_scrub

/* common/ctse_pkg.sv */
package ctse_pkg;
  // ------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int CHK_W = 6;
  localparam int CODE_W = 39;
  localparam int TAG_W = 28;
  localparam int TAG_CODE_W = 34;
  localparam int SETS = 512;
  localparam int WAYS = 16;
  localparam int IDX_W = 9;
  localparam int WAY_W = 4;
  localparam int PA_W = 40;
  localparam int SYN_W = 7;
  localparam int TGT_W = 6;
  // ------------------------------------------------------------
  // Scrub step counter
  // ------------------------------------------------------------
  localparam logic [2:0] STEP_TAG_READ = 3'h2;
  localparam logic [2:0] STEP_MUX = 3'h4;
  localparam logic [2:0] STEP_CORRECT = 3'h5;
  localparam logic [2:0] STEP_WRITE = 3'h7;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_ERR_LO = 12'h008;
  localparam logic [11:0] ADDR_ERR_HI = 12'h00C;
  localparam logic [11:0] ADDR_SCRUB = 12'h010;
  localparam int CTL_REPORT_EN_BIT = 0;
  localparam int CTL_TARGET_LSB = 8;
  localparam int STS_UE_BIT = 0;
  localparam int STS_CE_BIT = 1;
  localparam int STS_SYN_LSB = 8;
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  localparam logic [1:0] REPORT_CE_CODE = 2'h1;
  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    K_LOAD, K_STORE, K_ATOMIC, K_IFETCH, K_BLK_READ, K_PART_WRITE, K_WRITE_INV,
    K_EVICT, K_PF_FLUSH, K_DIAG, K_INVAL, K_TECC, K_FILL, K_OTHER
  } ctse_kind_type;
  typedef enum {S_IDLE, S_WALK} ctse_scrub_type;
  // ------------------------------------------------------------
  // Hamming check bits over 32 data bits
  // ------------------------------------------------------------
  function automatic logic [CHK_W-1:0] ctse_check(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    int j;
    c = '0;
    j = 0;
    for (int p = 1; p <= DATA_W + CHK_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        for (int b = 0; b < CHK_W; b++) begin
          if (p[b]) c[b] = c[b] ^ d[j];
        end
        j++;
      end
    end
    return c;
  endfunction : ctse_check
  // Full codeword: overall parity, check bits, data
  function automatic logic [CODE_W-1:0] ctse_encode(input logic [DATA_W-1:0] d);
    logic [CHK_W-1:0] c;
    c = ctse_check(d);
    return {^{d, c}, c, d};
  endfunction : ctse_encode
endpackage : ctse_pkg

/* src/ctse_secded.sv */
`timescale 1ns/1ps
module ctse_secded import ctse_pkg::*; #(
  parameter bit DED = 1'b1
) (
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [SYN_W-1:0] check_in,
  output logic [DATA_W-1:0] data_out,
  output logic [SYN_W-1:0] syndrome,
  output logic single_err,
  output logic double_err
);
  // ------------------------------------------------------------
  // Syndrome and single-bit correction
  // ------------------------------------------------------------
  logic [CHK_W-1:0] syn;
  logic par;
  always_comb begin
    int j;
    j = 0;
    syn = check_in[CHK_W-1:0] ^ ctse_check(data_in);
    par = DED ? ^{data_in, check_in} : 1'b0;
    data_out = data_in;
    for (int p = 1; p <= DATA_W + CHK_W; p++) begin
      if ((p & (p - 1)) != 0) begin
        if (syn == p[CHK_W-1:0]) data_out[j] = ~data_in[j];
        j++;
      end
    end
    syndrome = {par, syn};
    if (DED) begin
      single_err = par;
      double_err = (syn != '0) && !par;
    end else begin
      single_err = (syn != '0);
      double_err = 1'b0;
    end
  end
endmodule : ctse_secded

/* verification/ctse_chk.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Port checks
// ----------------------------------------
module ctse_chk import ctse_pkg::*; (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic C2_TAG_PERR,
  input wire logic FILL_DONE,
  input wire logic STALL_PIPE,
  input wire logic QUEUE_INSERT,
  input wire logic QUEUE_TAG_SCRUB,
  input wire logic QUEUE_DEP,
  input wire logic QUEUE_READY,
  input wire logic QUEUE_MEM_HOLD,
  input wire logic QUEUE_CE_REPLAY,
  input wire logic ERR_PKT_VALID,
  input wire logic [1:0] ERR_PKT_BITS
);
  logic [7:0] n_stall;
  always_ff @(posedge CLK) begin
    if (SRST) n_stall <= 8'h00;
    else n_stall <= STALL_PIPE ? n_stall + 8'h01 : 8'h00;
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);
  property p_ans; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
  a_ans: assert property (p_ans) else $error("ready late");
  property p_one; PREADY |=> !PREADY; endproperty
  a_one: assert property (p_one) else $error("ready held");
  property p_stall; $fell(STALL_PIPE) |-> n_stall == 8'h80; endproperty
  a_stall: assert property (p_stall) else $error("stall length");
  property p_tsc; QUEUE_TAG_SCRUB |-> $past(C2_TAG_PERR) && QUEUE_INSERT; endproperty
  a_tsc: assert property (p_tsc) else $error("scrub flag");
  property p_dep; QUEUE_DEP |-> QUEUE_INSERT; endproperty
  a_dep: assert property (p_dep) else $error("dependency alone");
  property p_mem; QUEUE_READY |-> QUEUE_MEM_HOLD; endproperty
  a_mem: assert property (p_mem) else $error("memory dispatch");
  property p_rep; QUEUE_CE_REPLAY |-> !$past(QUEUE_INSERT, 6); endproperty
  a_rep: assert property (p_rep) else $error("reinserted");
  property p_pkt; ERR_PKT_VALID |-> $past(FILL_DONE) && ERR_PKT_BITS == REPORT_CE_CODE; endproperty
  a_pkt: assert property (p_pkt) else $error("report packet");
  c_stall: cover property (STALL_PIPE);
  c_rdy: cover property (QUEUE_READY);
  c_pkt: cover property (ERR_PKT_VALID);
endmodule : ctse_chk
bind ctse_scrub ctse_chk i_chk (.*);

/* verification/ctse_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Requester: issues and replays queued work
// ----------------------------------------
module ctse_core_model import ctse_pkg::*; (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic go,
  input wire logic [3:0] kind,
  input wire logic [IDX_W-1:0] idx,
  input wire logic fsel,
  input wire logic fq,
  input wire logic STALL_PIPE,
  input wire logic QUEUE_READY,
  input wire logic QUEUE_CE_REPLAY,
  input wire logic QUEUE_EVICT_KEEP,
  output logic C1_VALID,
  output logic [3:0] C1_KIND,
  output logic C1_FROM_QUEUE,
  output logic [IDX_W-1:0] C1_INDEX,
  output logic [PA_W-1:0] C1_PA,
  output logic C1_FWD_SEL
);
  logic [3:0] k_keep;
  logic [IDX_W-1:0] i_keep;
  logic again;
  assign again = QUEUE_READY | QUEUE_CE_REPLAY | QUEUE_EVICT_KEEP;
  assign C1_PA = {31'h0000_1234, C1_INDEX};
  always_ff @(posedge CLK) begin
    if (SRST) begin
      C1_VALID <= 1'h0;
    end else if (go || again) begin
      C1_VALID <= 1'h1;
      C1_KIND <= go ? kind : k_keep;
      C1_INDEX <= go ? idx : i_keep;
      C1_FROM_QUEUE <= again | fq;
      C1_FWD_SEL <= go & fsel;
    end else if (!STALL_PIPE) begin
      C1_VALID <= 1'h0;
    end
  end
  always_ff @(posedge CLK) begin
    if (go && kind != K_TECC) begin
      k_keep <= kind;
      i_keep <= idx;
    end
  end
endmodule : ctse_core_model

/* verification/cache_tag_state_ecc_scrub_tb_top.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Bench
// ----------------------------------------
module cache_tag_state_ecc_scrub_tb_top import ctse_pkg::*; ;
  logic CLK = 1'h0, SRST = 1'h1, CE = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic C1_FB_HIT = 1'h0, C2_TAG_PERR = 1'h0, FILL_DONE = 1'h0, STATE_WR = 1'h0;
  logic STATE_WR_UA = 1'h0, STATE_WR_RAW = 1'h1, TAG_WR = 1'h0, TAG_WR_RAW = 1'h1;
  logic go = 1'h0, fsel = 1'h0, fq = 1'h0, slv;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, STATE_WR_DATA = '0, C1_FWD_VD = '0, C1_FWD_UA = '0, rd, PRDATA;
  logic [8:0] idx = '0, STATE_WR_INDEX = '0, TAG_WR_INDEX = 9'h003, C1_INDEX;
  logic [3:0] kind = '0, TAG_WR_WAY = '0, C1_KIND;
  logic [27:0] TAG_WR_DATA = 28'h0000001;
  logic [6:0] STATE_WR_CHECK = '0;
  logic [5:0] TAG_WR_CHECK = '0, ERR_PKT_TARGET;
  logic PREADY, PSLVERR, STALL_PIPE, QUEUE_INSERT, QUEUE_TAG_SCRUB, QUEUE_DEP, QUEUE_WRI_HOLD;
  logic DIR_GATE, CORE_RESP_GATE, SIU_RESP_GATE, WBB_COPY_GATE, QUEUE_READY, QUEUE_MEM_HOLD;
  logic QUEUE_CE_REPLAY, QUEUE_EVICT_KEEP, FATAL_RESET_REQ, ERR_PKT_VALID;
  logic C1_VALID, C1_FROM_QUEUE, C1_FWD_SEL;
  logic [1:0] ERR_PKT_BITS;
  logic [39:0] C1_PA;
  int n_errors = 0, n_compared = 0;
  int cnt [12];
  wire [11:0] ev = {SIU_RESP_GATE, CORE_RESP_GATE, DIR_GATE, QUEUE_WRI_HOLD,
    STALL_PIPE, QUEUE_TAG_SCRUB, ERR_PKT_VALID, WBB_COPY_GATE,
    QUEUE_EVICT_KEEP, QUEUE_CE_REPLAY, QUEUE_READY, QUEUE_INSERT};
  ctse_scrub i_dut (.*);
  ctse_core_model i_core (.*);
  always #12.5 CLK = ~CLK;
  always @(posedge CLK) begin
    for (int i = 0; i < 12; i++) cnt[i] += ev[i];
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLK) PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'h1;
    do @(posedge CLK); while (PREADY !== 1'h1);
    rd = PRDATA;
    slv = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask : apb
  task wst(input logic [8:0] i, input logic [31:0] d);
    @(posedge CLK) STATE_WR <= 1'h1;
    STATE_WR_INDEX <= i;
    STATE_WR_DATA <= d;
    STATE_WR_UA <= 1'h0;
    @(posedge CLK) STATE_WR_UA <= 1'h1;
    STATE_WR_DATA <= '0;
    @(posedge CLK) STATE_WR <= 1'h0;
  endtask : wst
  task run(input logic [3:0] k, input logic [8:0] i, input logic s, q, p);
    cnt = '{default: 0};
    @(posedge CLK) go <= 1'h1;
    kind <= k;
    idx <= i;
    fsel <= s;
    fq <= q;
    @(posedge CLK) go <= 1'h0;
    @(posedge CLK) C2_TAG_PERR <= p;
    @(posedge CLK) C2_TAG_PERR <= 1'h0;
    repeat (160) @(posedge CLK);
  endtask : run
  task t_sbe;
    wst(9'h005, 32'h1);
    run(K_LOAD, 9'h005, 1'h0, 1'h0, 1'h0);
    chk(cnt[0], 1);
    chk(cnt[1], 1);
    chk(cnt[9], 1);
    chk(cnt[10], 1);
    chk(cnt[11], 0);
    apb(1'h0, ADDR_STATUS, '0);
    chk(rd, 32'h0000_4302);
    apb(1'h0, ADDR_ERR_LO, '0);
    chk(rd, {23'h1234, 9'h005});
    apb(1'h1, ADDR_CONTROL, 32'h0000_2A01);
    @(posedge CLK) FILL_DONE <= 1'h1;
    @(posedge CLK) FILL_DONE <= 1'h0;
    repeat (3) @(posedge CLK);
    chk(cnt[5], 1);
    chk({26'h0, ERR_PKT_TARGET}, 32'h2A);
    apb(1'h1, ADDR_STATUS, 32'h3);
  endtask : t_sbe
  task t_skip;
    wst(9'h00B, 32'h1);
    run(K_LOAD, 9'h00B, 1'h1, 1'h0, 1'h0);
    chk(cnt[0], 0);
    wst(9'h00C, 32'h1);
    run(K_INVAL, 9'h00C, 1'h0, 1'h0, 1'h0);
    chk(cnt[0], 0);
    run(K_LOAD, 9'h00C, 1'h0, 1'h0, 1'h0);
    chk(cnt[0], 0);
    wst(9'h00D, 32'h1);
    C1_FB_HIT <= 1'h1;
    run(K_LOAD, 9'h00D, 1'h0, 1'h1, 1'h0);
    C1_FB_HIT <= 1'h0;
    chk(cnt[2], 0);
    apb(1'h0, ADDR_STATUS, '0);
    chk({31'h0, rd[STS_CE_BIT]}, 0);
  endtask : t_skip
  task t_queue;
    wst(9'h007, 32'h1);
    run(K_LOAD, 9'h007, 1'h0, 1'h1, 1'h0);
    chk(cnt[0], 0);
    chk(cnt[2], 1);
    wst(9'h008, 32'h1);
    run(K_EVICT, 9'h008, 1'h0, 1'h1, 1'h0);
    chk(cnt[3], 1);
    chk(cnt[4], 1);
    wst(9'h00A, 32'h1);
    run(K_WRITE_INV, 9'h00A, 1'h0, 1'h0, 1'h0);
    chk(cnt[8], 1);
    chk(cnt[9], 1);
    chk(cnt[10], 0);
    chk(cnt[11], 1);
  endtask : t_queue
  task t_scrub;
    for (int w = 0; w < 16; w++) begin
      @(posedge CLK) TAG_WR <= 1'h1;
      TAG_WR_WAY <= w[3:0];
    end
    @(posedge CLK) TAG_WR <= 1'h0;
    wst(9'h003, 32'h0);
    run(K_LOAD, 9'h003, 1'h0, 1'h0, 1'h1);
    chk(cnt[6], 1);
    run(K_TECC, 9'h003, 1'h0, 1'h0, 1'h0);
    chk(cnt[7], 128);
    apb(1'h0, ADDR_SCRUB, '0);
    chk({24'h0, rd[31:24]}, 32'h10);
    chk({21'h0, rd[10:0]}, 0);
    run(K_TECC, 9'h003, 1'h0, 1'h0, 1'h0);
    apb(1'h0, ADDR_SCRUB, '0);
    chk({24'h0, rd[31:24]}, 32'h10);
  endtask : t_scrub
  task t_ue;
    wst(9'h009, 32'h3);
    run(K_LOAD, 9'h009, 1'h0, 1'h0, 1'h0);
    chk({31'h0, FATAL_RESET_REQ}, 1);
    apb(1'h0, ADDR_STATUS, '0);
    chk({31'h0, rd[STS_UE_BIT]}, 1);
    @(posedge CLK) SRST <= 1'h1;
    @(posedge CLK) SRST <= 1'h0;
    @(posedge CLK);
    chk({31'h0, FATAL_RESET_REQ}, 0);
  endtask : t_ue
  task end_of_test;
    $display("mismatches %0d comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  initial begin
    #250000;
    n_errors++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge CLK);
    SRST <= 1'h0;
    apb(1'h0, ADDR_CONTROL, '0);
    chk(rd, CTL_RESET);
    apb(1'h0, 12'h020, '0);
    chk({31'h0, slv}, 1);
    t_sbe;
    t_skip;
    t_queue;
    t_scrub;
    t_ue;
    end_of_test;
  end
endmodule : cache_tag_state_ecc_scrub_tb_top
